//--- power_mode_controller.sv
/*
 * Power mode sequencer: RUN, SLOW, WAIT, SLOW-WAIT, ACTIVE-HALT, HALT,
 * clock enables, interrupt level forcing and oscillator restart delay.
 * Assumes the CPU pulses the wait and halt instructions, and the
 * interrupt controller reports pending and wake-capable requests.
 */
// Operation
// - After reset enter RUN mode with master clock at full rate.
// - Slow mode uses one enable bit plus a two-bit divider select.
// - Slow mode divides the master clock by 2, 4, 8 or 16.
// - Wait entered during slow mode gives slow-wait with divided peripherals.
// - Wait instruction stops only the CPU clock.
// - On wait entry the interrupt level bits are forced to 10.
// - Wait ends on any interrupt or reset, then service resumes.
// - Interrupt service pushes level bits; priority loaded; popped on return.
// - Halt instruction gives halt if oscillator enable is 0, else active-halt.
// - Active-halt keeps only oscillator and timebase counter running.
// - Active-halt exits on timebase, wake interrupt or reset, without delay.
// - Active-halt exit applies no stabilization delay, not even after reset.
// - Halt entry forces level bits to 10; pending interrupt wakes at once.
// - Active-halt with oscillator enable set gives no watchdog reset.
// - Halt stops the oscillator, CPU and all peripherals.
// - Halt exit restarts oscillator and waits 256 or 4096 cycles.
// - Halt with watchdog on may reset, per the watchdog halt option.
`timescale 1ns/1ns
module power_mode_controller
    import pmc_pkg::*;
(
    input  wire logic                  ref_clk,
    input  wire logic                  rstn,
    input  wire logic                  slow_mode_select,
    input  wire logic [DIV_SEL_W-1:0]  slow_divider_select,
    input  wire logic                  oscillator_interrupt_enable,
    input  wire logic                  watchdog_halt_option,
    input  wire logic                  watchdog_enabled,
    input  wire logic                  stab_long_select,
    input  wire logic                  wait_for_interrupt_instr,
    input  wire logic                  halt_instr,
    input  wire logic                  irq_pending,
    input  wire logic                  irq_wake_capable,
    input  wire logic                  timebase_irq,
    input  wire logic                  irq_accept,
    input  wire logic [1:0]            irq_priority,
    input  wire logic                  iret_pop,
    input  wire logic [1:0]            popped_level,
    input  wire logic                  level_write,
    input  wire logic [1:0]            level_wdata,
    output logic                       cpu_clk_en,
    output logic                       periph_clk_en,
    output logic                       timebase_clk_en,
    output logic                       osc_enable,
    output logic [1:0]                 condition_code_reg,
    output logic                       push_level,
    output logic [1:0]                 pushed_level,
    output logic                       service_start,
    output logic                       reset_vector_fetch,
    output logic                       watchdog_halt_reset,
    output logic [2:0]                 power_mode
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic [1:0]  rst_sync_r;
    logic        rst_n;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_r <= RST_SYNC_INIT;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // ------------------------------------------------------------------
    // Clock divider
    // ------------------------------------------------------------------
    pmc_clk_if cif ();

    assign cif.slow_on = slow_mode_select;
    assign cif.div_sel = slow_divider_select;

    pmc_clk_div u_div (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .cif     (cif)
    );

    // ------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------
    power_mode_t                mode_r;
    power_mode_t                mode_nxt;
    logic [STAB_CNT_W-1:0]      stab_cnt_r;
    logic [STAB_CNT_W-1:0]      stab_len;
    logic                       stab_done;
    logic                       halt_ok;
    logic                       wdg_trip;
    logic                       ah_wake;
    logic                       h_wake;
    logic [1:0]                 level_r;
    logic [1:0]                 level_nxt;
    logic                       enter_low;

    assign stab_len = stab_long_select ? STAB_CNT_W'(STAB_LONG_CYC - 1)
                                       : STAB_CNT_W'(STAB_SHORT_CYC - 1);
    assign stab_done = (stab_cnt_r == stab_len);

    // Watchdog reset on halt only without the oscillator interrupt.
    assign wdg_trip = watchdog_enabled && !watchdog_halt_option
                      && !oscillator_interrupt_enable;
    assign halt_ok  = halt_instr && !wdg_trip;

    assign ah_wake = timebase_irq || irq_wake_capable || irq_pending;
    assign h_wake  = irq_wake_capable || irq_pending;

    assign enter_low = (mode_r == MODE_RUN || mode_r == MODE_SLOW)
                       && (wait_for_interrupt_instr || halt_ok);

    // ------------------------------------------------------------------
    // Mode sequencing
    // ------------------------------------------------------------------
    always_comb begin
        mode_nxt = mode_r;
        unique case (mode_r)
            MODE_RUN, MODE_SLOW: begin
                if (halt_ok) begin
                    mode_nxt = oscillator_interrupt_enable
                               ? MODE_ACTIVE_HALT : MODE_HALT;
                end else if (wait_for_interrupt_instr) begin
                    mode_nxt = slow_mode_select
                               ? MODE_SLOW_WAIT : MODE_WAIT;
                end else begin
                    mode_nxt = slow_mode_select ? MODE_SLOW : MODE_RUN;
                end
            end
            MODE_WAIT, MODE_SLOW_WAIT: begin
                if (irq_pending) begin
                    mode_nxt = slow_mode_select ? MODE_SLOW : MODE_RUN;
                end
            end
            MODE_ACTIVE_HALT: begin
                if (ah_wake) begin
                    mode_nxt = slow_mode_select ? MODE_SLOW : MODE_RUN;
                end
            end
            MODE_HALT: begin
                if (h_wake) begin
                    mode_nxt = MODE_STABILIZE;
                end
            end
            MODE_STABILIZE: begin
                if (stab_done) begin
                    mode_nxt = slow_mode_select ? MODE_SLOW : MODE_RUN;
                end
            end
            default: begin
                mode_nxt = MODE_RUN;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= MODE_RUN;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stab_cnt_r <= '0;
        end else if (mode_r == MODE_STABILIZE) begin
            stab_cnt_r <= stab_cnt_r + 13'h1;
        end else begin
            stab_cnt_r <= '0;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt level bits
    // ------------------------------------------------------------------
    // Low power entry outranks any other update in the same cycle.
    always_comb begin
        level_nxt = level_r;
        if (enter_low) begin
            level_nxt = ILEVEL_WAKE;
        end else if (irq_accept) begin
            level_nxt = irq_priority;
        end else if (iret_pop) begin
            level_nxt = popped_level;
        end else if (level_write) begin
            level_nxt = level_wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            level_r <= ILEVEL_RESET;
        end else begin
            level_r <= level_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------
    logic  wake_srv;
    logic  cpu_run;
    logic  per_run;

    assign wake_srv = mode_r != MODE_RUN && mode_r != MODE_SLOW
                      && (mode_nxt == MODE_RUN || mode_nxt == MODE_SLOW);
    assign cpu_run  = mode_nxt == MODE_RUN || mode_nxt == MODE_SLOW;
    assign per_run  = cpu_run || mode_nxt == MODE_WAIT
                      || mode_nxt == MODE_SLOW_WAIT;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_clk_en          <= 1'b0;
            periph_clk_en       <= 1'b0;
            timebase_clk_en     <= 1'b0;
            osc_enable          <= 1'b1;
            condition_code_reg  <= ILEVEL_RESET;
            push_level          <= 1'b0;
            pushed_level        <= ILEVEL_RESET;
            service_start       <= 1'b0;
            reset_vector_fetch  <= 1'b0;
            watchdog_halt_reset <= 1'b0;
            power_mode          <= MODE_RUN;
        end else begin
            cpu_clk_en          <= cpu_run && cif.tick;
            periph_clk_en       <= per_run && cif.tick;
            timebase_clk_en     <= mode_nxt != MODE_HALT;
            osc_enable          <= mode_nxt != MODE_HALT;
            condition_code_reg  <= level_nxt;
            push_level          <= irq_accept;
            pushed_level        <= irq_accept ? level_r : pushed_level;
            service_start       <= wake_srv;
            reset_vector_fetch  <= !reset_vector_fetch && mode_r == MODE_RUN
                                   && power_mode == MODE_RUN
                                   && !service_start && 1'b0;
            watchdog_halt_reset <= halt_instr && wdg_trip && enter_low == 1'b0
                                   && (mode_r == MODE_RUN
                                       || mode_r == MODE_SLOW);
            power_mode          <= mode_nxt;
        end
    end

endmodule : power_mode_controller

//--- pmc_pkg.sv
/*
 * Shared constants and types of the power mode controller.
 * Assumes a single 100 MHz clock; no register bus is present.
 */
package pmc_pkg;

    // ------------------------------------------------------------------
    // Modes and fields
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_RUN         = 3'h0,
        MODE_SLOW        = 3'h1,
        MODE_WAIT        = 3'h2,
        MODE_SLOW_WAIT   = 3'h3,
        MODE_ACTIVE_HALT = 3'h4,
        MODE_HALT        = 3'h5,
        MODE_STABILIZE   = 3'h6
    } power_mode_t;

    localparam logic [1:0]  ILEVEL_WAKE     = 2'h2;
    localparam logic [1:0]  ILEVEL_RESET    = 2'h3;
    localparam int          DIV_SEL_W       = 2;
    localparam int          DIV_CNT_W       = 4;
    localparam int          STAB_CNT_W      = 13;
    localparam int          STAB_SHORT_CYC  = 256;
    localparam int          STAB_LONG_CYC   = 4096;
    localparam logic [1:0]  RST_SYNC_INIT   = 2'h0;

endpackage : pmc_pkg

//--- pmc_clk_if.sv
/*
 * Clock enable bundle between the sequencer and its divider.
 * Assumes both ends run on ref_clk.
 */
`timescale 1ns/1ns
interface pmc_clk_if;
    import pmc_pkg::*;

    logic                  slow_on;
    logic [DIV_SEL_W-1:0]  div_sel;
    logic                  tick;

    modport ctrl (output slow_on, output div_sel, input  tick);
    modport div  (input  slow_on, input  div_sel, output tick);
endinterface : pmc_clk_if

//--- pmc_clk_div.sv
/*
 * Master clock enable divider: full rate, or divided by 2, 4, 8 or 16.
 * Assumes an asynchronous active-low reset already released cleanly.
 */
`timescale 1ns/1ns
module pmc_clk_div
    import pmc_pkg::*;
(
    input  wire logic  ref_clk,
    input  wire logic  rst_n,
    pmc_clk_if.div     cif
);

    logic [DIV_CNT_W-1:0]  cnt_r;
    logic [DIV_CNT_W-1:0]  mask;

    // Select 0..3 gives masks 1, 3, 7, 15: divide by 2, 4, 8, 16.
    assign mask = DIV_CNT_W'((5'h2 << cif.div_sel) - 5'h1);

    assign cif.tick = !cif.slow_on || ((cnt_r & mask) == mask);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 4'h1;
        end
    end

endmodule : pmc_clk_div

//--- pmc_checker.sv
/* Port assertions of the power mode controller.
   Bound to power_mode_controller; sees only its ports. */
`timescale 1ns/1ns
module pmc_checker (
    input wire logic       ref_clk,
    input wire logic       rstn,
    input wire logic       oscillator_interrupt_enable,
    input wire logic       watchdog_halt_option,
    input wire logic       watchdog_enabled,
    input wire logic       stab_long_select,
    input wire logic       wait_for_interrupt_instr,
    input wire logic       halt_instr,
    input wire logic       irq_pending,
    input wire logic       timebase_irq,
    input wire logic       irq_accept,
    input wire logic [1:0] irq_priority,
    input wire logic       cpu_clk_en,
    input wire logic       periph_clk_en,
    input wire logic       timebase_clk_en,
    input wire logic       osc_enable,
    input wire logic [1:0] condition_code_reg,
    input wire logic       push_level,
    input wire logic [1:0] pushed_level,
    input wire logic       service_start,
    input wire logic       watchdog_halt_reset,
    input wire logic [2:0] power_mode
);
    // ------------------------------------------------------------------
    // Mode entry, clock gating, wake-up and level push
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    wire run_halt = power_mode == 3'h0 && halt_instr;
    wire trip     = watchdog_enabled && !watchdog_halt_option;
    wire to_wait  = wait_for_interrupt_instr && !halt_instr;

    a_halt_gating: assert property (power_mode == 3'h5 |->
        !osc_enable && !cpu_clk_en && !periph_clk_en) else $error("halt gate");
    a_ahalt_clocks: assert property (power_mode == 3'h4 |->
        timebase_clk_en && osc_enable && !periph_clk_en && !cpu_clk_en)
        else $error("active-halt clocks");
    a_halt_entry: assert property (run_halt && !oscillator_interrupt_enable
        && !trip |=> power_mode == 3'h5 && condition_code_reg == 2'h2)
        else $error("halt entry");
    a_ahalt_entry: assert property (run_halt && oscillator_interrupt_enable
        |=> power_mode == 3'h4 && !watchdog_halt_reset
        && condition_code_reg == 2'h2) else $error("active-halt entry");
    a_wdg_trip: assert property (run_halt && !oscillator_interrupt_enable
        && trip |=> power_mode == 3'h0 && watchdog_halt_reset)
        else $error("watchdog trip");
    a_wait_entry: assert property (power_mode == 3'h0 && to_wait |=>
        power_mode == 3'h2 && condition_code_reg == 2'h2 && !cpu_clk_en
        && periph_clk_en) else $error("wait entry");
    a_slow_wait: assert property (power_mode == 3'h1 && to_wait |=>
        power_mode == 3'h3 && !cpu_clk_en) else $error("slow-wait entry");
    a_wait_wake: assert property (power_mode == 3'h2 && irq_pending |=>
        power_mode == 3'h0 && service_start) else $error("wait wake");
    a_ahalt_fast: assert property (power_mode == 3'h4 && timebase_irq |=>
        power_mode == 3'h0 && service_start) else $error("active-halt wake");
    a_level_push: assert property (irq_accept |=> push_level
        && pushed_level == $past(condition_code_reg)
        && condition_code_reg == $past(irq_priority)) else $error("push");
    a_stab_delay: assert property ($rose(power_mode == 3'h6)
        && !stab_long_select |-> ##255 power_mode == 3'h6 ##1
        (power_mode == 3'h0 && service_start)) else $error("stab delay");

    c_slow_wait: cover property (power_mode == 3'h3);
    c_stab: cover property (power_mode == 3'h6);
    c_trip: cover property (watchdog_halt_reset);
endmodule : pmc_checker

bind power_mode_controller pmc_checker pmc_checker_inst (.*);

//--- cpu_irq_model.sv
/* CPU core model: starts an interrupt routine after each wake-up.
   Assumes service_start is a one-cycle pulse on ref_clk. */
`timescale 1ns/1ns
module cpu_irq_model (
    input  wire logic       ref_clk,
    input  wire logic       service_start,
    output logic            irq_accept,
    output logic [1:0]      irq_priority
);
    assign irq_priority = 2'h1;
    initial irq_accept = 1'b0;
    always @(posedge ref_clk) irq_accept <= service_start;
endmodule : cpu_irq_model

//--- power_mode_controller_tb.sv
/* Self-checking bench of the power mode controller.
   Assumes pmc_pkg, the design files, checker and CPU model. */
`timescale 1ns/1ns
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin n_fail++; \
    $display("BAD %s exp %0h got %0h", n, e, s); end end
module power_mode_controller_tb;
    import pmc_pkg::*;
    logic ref_clk = 1'b0, rstn = 1'b0, slow_mode_select = 1'b0;
    logic oscillator_interrupt_enable = 1'b0, watchdog_halt_option = 1'b0;
    logic watchdog_enabled = 1'b0, stab_long_select = 1'b0;
    logic wait_for_interrupt_instr = 1'b0, halt_instr = 1'b0;
    logic irq_pending = 1'b0, irq_wake_capable = 1'b0, timebase_irq = 1'b0;
    logic iret_pop = 1'b0, level_write = 1'b0;
    logic [1:0] slow_divider_select = 2'h0, popped_level = 2'h0;
    logic [1:0] level_wdata = 2'h0;
    wire irq_accept, cpu_clk_en, periph_clk_en, timebase_clk_en, osc_enable;
    wire push_level, service_start, reset_vector_fetch, watchdog_halt_reset;
    wire [1:0] irq_priority, condition_code_reg, pushed_level;
    wire [2:0] power_mode;
    int n_fail = 0, tests_run = 0, cyc = 0;

    power_mode_controller power_mode_controller_inst (.*);
    cpu_irq_model cpu_irq_model_inst (.*);

    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            close_out;
        end
    end

    task tk; @(posedge ref_clk); #1; endtask : tk
    task pls(input logic h);
        @(posedge ref_clk);
        if (h) halt_instr <= 1'b1; else wait_for_interrupt_instr <= 1'b1;
        @(posedge ref_clk);
        halt_instr <= 1'b0;
        wait_for_interrupt_instr <= 1'b0;
        #1;
    endtask : pls
    task wait_ss(output int n6);
        n6 = 0;
        for (int k = 0; k < 6000 && service_start !== 1'b1; k++) begin
            if (power_mode === 3'h6) n6++;
            tk;
        end
    endtask : wait_ss
    task wake(input logic w);
        int n;
        @(posedge ref_clk);
        if (w) irq_wake_capable <= 1'b1; else irq_pending <= 1'b1;
        #1;
        wait_ss(n);
        `CHK("wake", 1'b1, service_start)
        @(posedge ref_clk);
        irq_wake_capable <= 1'b0;
        irq_pending <= 1'b0;
        #1;
    endtask : wake
    task count_en(output int c, output int p);
        c = 0;
        p = 0;
        repeat (64) begin
            tk;
            c += cpu_clk_en;
            p += periph_clk_en;
        end
    endtask : count_en

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task t_reset;
        `CHK("mode", 3'h0, power_mode)
        `CHK("cpu en", 1'b1, cpu_clk_en)
        `CHK("level", 2'h3, condition_code_reg)
        `CHK("vector", 1'b0, reset_vector_fetch)
    endtask : t_reset
    task t_wait;
        pls(1'b0);
        `CHK("mode", 3'h2, power_mode)
        `CHK("periph", 2'h1, {cpu_clk_en, periph_clk_en})
        `CHK("level", 2'h2, condition_code_reg)
        wake(1'b0);
        tk;
        `CHK("push", 3'h6, {push_level, pushed_level})
        `CHK("prio", 2'h1, condition_code_reg)
        @(posedge ref_clk);
        popped_level <= 2'h3;
        iret_pop <= 1'b1;
        @(posedge ref_clk);
        iret_pop <= 1'b0;
        #1;
        `CHK("pop", 2'h3, condition_code_reg)
        @(posedge ref_clk);
        level_wdata <= 2'h1;
        level_write <= 1'b1;
        @(posedge ref_clk);
        level_write <= 1'b0;
        #1;
        `CHK("write", 2'h1, condition_code_reg)
    endtask : t_wait
    task t_slow;
        int c, p;
        @(posedge ref_clk) slow_mode_select <= 1'b1;
        for (int d = 0; d < 4; d++) begin
            @(posedge ref_clk) slow_divider_select <= d[1:0];
            repeat (20) tk;
            count_en(c, p);
            `CHK("ticks", 64 >> (d + 1), c)
        end
        pls(1'b0);
        `CHK("mode", 3'h3, power_mode)
        count_en(c, p);
        `CHK("sw cpu", 0, c)
        `CHK("sw per", 4, p)
        wake(1'b0);
        @(posedge ref_clk) slow_mode_select <= 1'b0;
        repeat (4) tk;
    endtask : t_slow
    task t_halt;
        int n;
        pls(1'b1);
        `CHK("mode", 3'h5, power_mode)
        `CHK("osc", 2'h0, {osc_enable, periph_clk_en})
        `CHK("level", 2'h2, condition_code_reg)
        @(posedge ref_clk) irq_wake_capable <= 1'b1;
        #1;
        wait_ss(n);
        `CHK("stab", STAB_SHORT_CYC, n)
        `CHK("osc", 1'b1, osc_enable)
        @(posedge ref_clk) irq_wake_capable <= 1'b0;
        repeat (3) tk;
    endtask : t_halt
    task t_ahalt;
        @(posedge ref_clk);
        oscillator_interrupt_enable <= 1'b1;
        watchdog_enabled <= 1'b1;
        pls(1'b1);
        `CHK("mode", 3'h4, power_mode)
        `CHK("wdg", 1'b0, watchdog_halt_reset)
        `CHK("tb en", 2'h2, {timebase_clk_en, periph_clk_en})
        @(posedge ref_clk) timebase_irq <= 1'b1;
        @(posedge ref_clk) timebase_irq <= 1'b0;
        #1;
        `CHK("fast", 4'h1, {power_mode, service_start})
        @(posedge ref_clk) irq_pending <= 1'b1;
        pls(1'b1);
        repeat (2) tk;
        `CHK("pend", 3'h0, power_mode)
        @(posedge ref_clk) irq_pending <= 1'b0;
        repeat (3) tk;
    endtask : t_ahalt
    task t_wdg;
        int n;
        @(posedge ref_clk) oscillator_interrupt_enable <= 1'b0;
        pls(1'b1);
        `CHK("trip", 4'h1, {power_mode, watchdog_halt_reset})
        @(posedge ref_clk) watchdog_halt_option <= 1'b1;
        stab_long_select <= 1'b1;
        pls(1'b1);
        `CHK("compat", 3'h5, power_mode)
        @(posedge ref_clk) irq_wake_capable <= 1'b1;
        #1;
        wait_ss(n);
        `CHK("long", STAB_LONG_CYC, n)
        `CHK("wake", 1'b1, service_start)
        @(posedge ref_clk) irq_wake_capable <= 1'b0;
        repeat (3) tk;
    endtask : t_wdg

    task close_out;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out

    initial begin
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (3) tk;
        t_reset;
        t_wait;
        t_slow;
        t_halt;
        t_ahalt;
        t_wdg;
        close_out;
    end
endmodule : power_mode_controller_tb
